/* File: core/aic_alarm_indicator.sv */
`timescale 1ns/100ps
// How it works
// - Blue solid while system is active
// - Display follows highest-severity active condition only
// - Warm-up cycles green, amber, red repeatedly
// - Warm-up done: all three solid, silent
// - Self-check: red/green toggle, amber solid
// - Self-check done: green flashes slowly
// - After confirmation alarm logic drives LEDs
// - No alarm: green solid, audio silent
// - Low alarm: amber solid, no tone
// - Medium alarm: amber flashes 1 Hz, 50%
// - Medium tone: equal notes C, D, G
// - Tone mutable for 120 s, then resumes
// - High alarm: red flashes 2.5 Hz, 50%
// - High tone: short C D G, long C D
// - High alarm inhibits delivery
// - Medium alarm keeps delivery permitted
// - Active: show idle when recycled exceeds setpoint
module aic_alarm_indicator #(
  parameter int N_COND = 8,
  parameter int FRAC_W = 8,
  parameter int TICK_CYC = aic_pkg::TICK_CYC,
  parameter int MUTE_TICKS = aic_pkg::MUTE_TICKS,
  parameter int MED_HALF = aic_pkg::MED_HALF_TICKS,
  parameter int HI_HALF = aic_pkg::HI_HALF_TICKS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // System controller
  input wire aic_pkg::aic_phase_e phase,
  input wire logic sys_active,
  input wire logic [N_COND-1:0] alarm_high,
  input wire logic [N_COND-1:0] alarm_med,
  input wire logic [N_COND-1:0] alarm_low,
  input wire logic [FRAC_W-1:0] recycled_agent_fraction,
  input wire logic [FRAC_W-1:0] inspired_setpoint,
  // Indicators
  output aic_pkg::aic_led_s leds,
  output logic [1:0] tone_note,
  output logic delivery_ok,
  output logic delivery_idle,
  output logic irq
);
  logic [17:0] tick_cnt_r;
  logic tick_r;
  logic [1:0] blink_r;
  logic [1:0] blink_adv;
  logic [1:0] warm_idx_r;
  aic_pkg::aic_sev_e sev_r;
  aic_pkg::aic_sev_e sev_nxt;
  logic [16:0] mute_cnt_r;
  logic [2:0] step_r;
  logic [9:0] note_cnt_r;
  logic [1:0] seq_note;
  logic [9:0] seq_len;
  logic seq_last;
  logic sounding;
  aic_pkg::aic_led_s leds_r;
  aic_pkg::aic_led_s leds_nxt;
  logic [1:0] tone_r;
  logic deliv_ok_r;
  logic deliv_idle_r;
  logic tone_en_r;
  logic [aic_pkg::IRQ_W-1:0] irq_stat_r;
  logic [aic_pkg::IRQ_W-1:0] irq_mask_r;
  logic [aic_pkg::IRQ_W-1:0] irq_ev;
  logic irq_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic mute_req;
  logic esc_ev;

  // Millisecond tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_r <= 18'h0;
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r == 18'(TICK_CYC - 1))
    begin
      tick_cnt_r <= 18'h0;
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 18'h1;
      tick_r <= 1'b0;
    end
  end

  // Two blink generators, slow and fast
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_blink
      localparam int HALF = (i == 0) ? MED_HALF : HI_HALF;
      logic [9:0] cnt_r;
      assign blink_adv[i] = tick_r && (cnt_r == 10'(HALF - 1));
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          cnt_r <= 10'h0;
          blink_r[i] <= 1'b0;
        end
        else if (blink_adv[i])
        begin
          cnt_r <= 10'h0;
          blink_r[i] <= ~blink_r[i];
        end
        else if (tick_r)
          cnt_r <= cnt_r + 10'h1;
      end
    end
  endgenerate

  // Warm-up colour rotation
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      warm_idx_r <= 2'h0;
    else if (phase != aic_pkg::PH_WARM)
      warm_idx_r <= 2'h0;
    else if (blink_adv[0])
      warm_idx_r <= (warm_idx_r == 2'h2) ? 2'h0 : warm_idx_r + 2'h1;
  end

  // Severity select
  always_comb
  begin
    if (|alarm_high)
      sev_nxt = aic_pkg::SEV_HIGH;
    else if (|alarm_med)
      sev_nxt = aic_pkg::SEV_MED;
    else if (|alarm_low)
      sev_nxt = aic_pkg::SEV_LOW;
    else
      sev_nxt = aic_pkg::SEV_NONE;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sev_r <= aic_pkg::SEV_NONE;
    else
      sev_r <= sev_nxt;
  end

  // Mute timer; a new request restarts the full interval
  assign mute_req = wr_pend_r && (wr_addr_r == aic_pkg::OFS_CTRL) &&
                    hwdata[aic_pkg::CTRL_MUTE_BIT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mute_cnt_r <= 17'h0;
    else if (mute_req && (sev_r == aic_pkg::SEV_MED || sev_r == aic_pkg::SEV_HIGH))
      mute_cnt_r <= 17'(MUTE_TICKS);
    else if (tick_r && mute_cnt_r != 17'h0)
      mute_cnt_r <= mute_cnt_r - 17'h1;
  end

  // Tone sequence tables
  always_comb
  begin
    seq_note = aic_pkg::NOTE_OFF;
    seq_len = 10'(aic_pkg::SEQ_PAUSE_MS);
    seq_last = 1'b0;
    if (sev_r == aic_pkg::SEV_HIGH)
    begin
      case (step_r)
        3'h0: seq_note = aic_pkg::NOTE_C;
        3'h1: seq_note = aic_pkg::NOTE_D;
        3'h2: seq_note = aic_pkg::NOTE_G;
        3'h3: seq_note = aic_pkg::NOTE_C;
        3'h4: seq_note = aic_pkg::NOTE_D;
        default: seq_last = 1'b1;
      endcase
      if (step_r < 3'h3)
        seq_len = 10'(aic_pkg::NOTE_SHORT_MS);
      else if (step_r < 3'h5)
        seq_len = 10'(aic_pkg::NOTE_LONG_MS);
    end
    else
    begin
      case (step_r)
        3'h0: seq_note = aic_pkg::NOTE_C;
        3'h1: seq_note = aic_pkg::NOTE_D;
        3'h2: seq_note = aic_pkg::NOTE_G;
        default: seq_last = 1'b1;
      endcase
      if (step_r < 3'h3)
        seq_len = 10'(aic_pkg::NOTE_MED_MS);
    end
  end

  // Only medium and high sound, and only once alarm logic owns outputs
  assign sounding = (phase == aic_pkg::PH_RUN) && tone_en_r &&
                    (sev_r == aic_pkg::SEV_MED || sev_r == aic_pkg::SEV_HIGH);

  // Sequence restarts whenever severity changes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      step_r <= 3'h0;
      note_cnt_r <= 10'h0;
    end
    else if (!sounding || sev_nxt != sev_r)
    begin
      step_r <= 3'h0;
      note_cnt_r <= 10'h0;
    end
    else if (tick_r)
    begin
      if (note_cnt_r == seq_len - 10'h1)
      begin
        note_cnt_r <= 10'h0;
        step_r <= seq_last ? 3'h0 : step_r + 3'h1;
      end
      else
        note_cnt_r <= note_cnt_r + 10'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tone_r <= aic_pkg::NOTE_OFF;
    else if (sounding && mute_cnt_r == 17'h0)
      tone_r <= seq_note;
    else
      tone_r <= aic_pkg::NOTE_OFF;
  end

  // LED pattern
  always_comb
  begin
    leds_nxt = '0;
    leds_nxt.blue = sys_active;
    case (phase)
      aic_pkg::PH_WARM:
      begin
        leds_nxt.green = (warm_idx_r == 2'h0);
        leds_nxt.amber = (warm_idx_r == 2'h1);
        leds_nxt.red = (warm_idx_r == 2'h2);
      end
      aic_pkg::PH_WARM_DONE:
      begin
        leds_nxt.green = 1'b1;
        leds_nxt.amber = 1'b1;
        leds_nxt.red = 1'b1;
      end
      aic_pkg::PH_CHECK:
      begin
        leds_nxt.red = blink_r[0];
        leds_nxt.green = ~blink_r[0];
        leds_nxt.amber = 1'b1;
      end
      aic_pkg::PH_CHECK_DONE:
        leds_nxt.green = blink_r[0];
      aic_pkg::PH_RUN:
      begin
        case (sev_r)
          aic_pkg::SEV_HIGH: leds_nxt.red = blink_r[1];
          aic_pkg::SEV_MED: leds_nxt.amber = blink_r[0];
          aic_pkg::SEV_LOW: leds_nxt.amber = 1'b1;
          default: leds_nxt.green = 1'b1;
        endcase
      end
      default: leds_nxt.red = 1'b1;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      leds_r <= '0;
    else
      leds_r <= leds_nxt;
  end

  // Delivery indications
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      deliv_ok_r <= 1'b0;
      deliv_idle_r <= 1'b0;
    end
    else
    begin
      deliv_ok_r <= sys_active && (phase == aic_pkg::PH_RUN) &&
                    (sev_r != aic_pkg::SEV_HIGH);
      deliv_idle_r <= sys_active && (recycled_agent_fraction > inspired_setpoint);
    end
  end

  // Interrupt events; set wins over a write-one clear
  assign esc_ev = (phase == aic_pkg::PH_RUN) && (sev_nxt > sev_r);
  assign irq_ev[aic_pkg::IRQ_ESCALATE_BIT] = esc_ev;
  assign irq_ev[aic_pkg::IRQ_HIGH_BIT] = esc_ev && (sev_nxt == aic_pkg::SEV_HIGH);
  assign irq_ev[aic_pkg::IRQ_MUTE_END_BIT] = tick_r && (mute_cnt_r == 17'h1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_r <= '0;
    else if (wr_pend_r && wr_addr_r == aic_pkg::OFS_IRQ_STAT)
      irq_stat_r <= (irq_stat_r & ~hwdata[aic_pkg::IRQ_W-1:0]) | irq_ev;
    else
      irq_stat_r <= irq_stat_r | irq_ev;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_stat_r & irq_mask_r);
  end

  // Bus slave: zero wait, writes land in the data phase
  assign addr_ok = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tone_en_r <= aic_pkg::CTRL_TONE_EN_RST;
      irq_mask_r <= aic_pkg::IRQ_MASK_RST;
    end
    else if (wr_pend_r && wr_addr_r == aic_pkg::OFS_CTRL)
      tone_en_r <= hwdata[aic_pkg::CTRL_TONE_EN_BIT];
    else if (wr_pend_r && wr_addr_r == aic_pkg::OFS_IRQ_MASK)
      irq_mask_r <= hwdata[aic_pkg::IRQ_W-1:0];
  end

  always_comb
  begin
    rd_mux = 32'h0;
    if (haddr[7:0] == aic_pkg::OFS_CTRL)
      rd_mux[aic_pkg::CTRL_TONE_EN_BIT] = tone_en_r;
    else if (haddr[7:0] == aic_pkg::OFS_STATUS)
    begin
      rd_mux[aic_pkg::ST_SEV_LSB +: 4] = sev_r;
      rd_mux[aic_pkg::ST_MUTED_BIT] = (mute_cnt_r != 17'h0);
      rd_mux[aic_pkg::ST_LED_LSB +: 4] = leds_r;
      rd_mux[aic_pkg::ST_DELIV_OK_BIT] = deliv_ok_r;
      rd_mux[aic_pkg::ST_DELIV_IDLE_BIT] = deliv_idle_r;
    end
    else if (haddr[7:0] == aic_pkg::OFS_IRQ_STAT)
      rd_mux[aic_pkg::IRQ_W-1:0] = irq_stat_r;
    else if (haddr[7:0] == aic_pkg::OFS_IRQ_MASK)
      rd_mux[aic_pkg::IRQ_W-1:0] = irq_mask_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0;
    else if (addr_ok && !hwrite)
      hrdata_r <= rd_mux;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign leds = leds_r;
  assign tone_note = tone_r;
  assign delivery_ok = deliv_ok_r;
  assign delivery_idle = deliv_idle_r;
  assign irq = irq_r;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_mute_taken;
    mute_req && (sev_r == aic_pkg::SEV_MED || sev_r == aic_pkg::SEV_HIGH);
  endsequence
  sequence s_silent;
    (tone_r == aic_pkg::NOTE_OFF)[*8];
  endsequence

  a_blue_follows: assert property (sys_active |=> leds_r.blue)
    else $error("blue not lit while active");
  a_warm_onehot: assert property ((phase == aic_pkg::PH_WARM)[*2] |->
    $onehot({leds_r.red, leds_r.amber, leds_r.green}))
    else $error("warm-up not single colour");
  a_warm_done: assert property ((phase == aic_pkg::PH_WARM_DONE) |=>
    leds_r.red && leds_r.amber && leds_r.green && tone_r == aic_pkg::NOTE_OFF)
    else $error("warm done pattern wrong");
  a_check_amber: assert property ((phase == aic_pkg::PH_CHECK) |=>
    leds_r.amber && (leds_r.red != leds_r.green))
    else $error("self-check pattern wrong");
  a_none_green: assert property ((phase == aic_pkg::PH_RUN && sev_r == aic_pkg::SEV_NONE)
    |=> leds_r.green && !leds_r.amber && tone_r == aic_pkg::NOTE_OFF)
    else $error("normal state wrong");
  a_low_amber: assert property ((phase == aic_pkg::PH_RUN && sev_r == aic_pkg::SEV_LOW)
    |=> leds_r.amber && !leds_r.green && !leds_r.red)
    else $error("low alarm pattern wrong");
  a_high_red: assert property ((phase == aic_pkg::PH_RUN && sev_r == aic_pkg::SEV_HIGH)
    |=> !leds_r.amber && !leds_r.green && leds_r.red == $past(blink_r[1]))
    else $error("high alarm pattern wrong");
  a_mute_silence: assert property (s_mute_taken |=> ##1 s_silent)
    else $error("tone not muted");
  a_high_inhibit: assert property (sev_r == aic_pkg::SEV_HIGH |=> !deliv_ok_r)
    else $error("delivery allowed in high alarm");
  a_med_permit: assert property ((sys_active && phase == aic_pkg::PH_RUN &&
    sev_r == aic_pkg::SEV_MED) |=> deliv_ok_r)
    else $error("delivery blocked in medium alarm");
  a_idle_flag: assert property ((sys_active &&
    recycled_agent_fraction > inspired_setpoint) |=> deliv_idle_r)
    else $error("idle not shown");
  a_sev_rank: assert property (|alarm_high |=> sev_r == aic_pkg::SEV_HIGH)
    else $error("severity order wrong");
endmodule // aic_alarm_indicator

/* File: core/aic_pkg.sv */
package aic_pkg;
  // Clock and timing base
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  // Blink rates, 50% duty
  localparam int MED_BLINK_PERIOD_MS = 1000;
  localparam int HI_BLINK_PERIOD_MS = 400;
  localparam int DUTY_PCT = 50;
  localparam int MED_HALF_TICKS = MED_BLINK_PERIOD_MS * DUTY_PCT / 100;
  localparam int HI_HALF_TICKS = HI_BLINK_PERIOD_MS * DUTY_PCT / 100;
  // Mute interval
  localparam int MUTE_S = 120;
  localparam int MUTE_TICKS = MUTE_S * MS_PER_S;
  // Note lengths
  localparam int NOTE_MED_MS = 200;
  localparam int NOTE_SHORT_MS = 100;
  localparam int NOTE_LONG_MS = 300;
  localparam int SEQ_PAUSE_MS = 1000;
  // Register map, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  // Field positions
  localparam int CTRL_MUTE_BIT = 0;
  localparam int CTRL_TONE_EN_BIT = 1;
  localparam int ST_SEV_LSB = 0;
  localparam int ST_MUTED_BIT = 4;
  localparam int ST_LED_LSB = 8;
  localparam int ST_DELIV_OK_BIT = 12;
  localparam int ST_DELIV_IDLE_BIT = 13;
  localparam int IRQ_ESCALATE_BIT = 0;
  localparam int IRQ_HIGH_BIT = 1;
  localparam int IRQ_MUTE_END_BIT = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic CTRL_TONE_EN_RST = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // Tone note codes
  localparam logic [1:0] NOTE_OFF = 2'h0;
  localparam logic [1:0] NOTE_C = 2'h1;
  localparam logic [1:0] NOTE_D = 2'h2;
  localparam logic [1:0] NOTE_G = 2'h3;

  typedef enum logic [4:0] {
    PH_WARM = 5'b00001,
    PH_WARM_DONE = 5'b00010,
    PH_CHECK = 5'b00100,
    PH_CHECK_DONE = 5'b01000,
    PH_RUN = 5'b10000
  } aic_phase_e;

  typedef enum logic [3:0] {
    SEV_NONE = 4'b0001,
    SEV_LOW = 4'b0010,
    SEV_MED = 4'b0100,
    SEV_HIGH = 4'b1000
  } aic_sev_e;

  typedef struct packed {
    logic red;
    logic amber;
    logic green;
    logic blue;
  } aic_led_s;
endpackage

/* File: verif/aic_alarm_indicator_tb.sv */
`timescale 1ns/100ps
module aic_alarm_indicator_tb;
  // Short tick keeps blink periods to tens of cycles; tone notes still last 1000 to 3000 cycles
  localparam int TK = 10;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  aic_pkg::aic_phase_e phase;
  logic sys_active;
  logic [7:0] alarm_high, alarm_med, alarm_low, frac, setp;
  aic_pkg::aic_led_s leds;
  logic [3:0] lv;
  logic [1:0] tone_note;
  logic delivery_ok, delivery_idle, irq;
  int mismatches;
  int checks;
  int n;
  logic [31:0] rd;
  logic [3:0] hi, lo;
  logic tn;

  assign lv = leds;

  aic_alarm_indicator #(.TICK_CYC(TK), .MUTE_TICKS(20), .MED_HALF(5), .HI_HALF(2)) dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(),
    .phase(phase),
    .sys_active(sys_active),
    .alarm_high(alarm_high),
    .alarm_med(alarm_med),
    .alarm_low(alarm_low),
    .recycled_agent_fraction(frac),
    .inspired_setpoint(setp),
    .leds(leds),
    .tone_note(tone_note),
    .delivery_ok(delivery_ok),
    .delivery_idle(delivery_idle),
    .irq(irq)
  );

  aic_sys_model sys (
    .hclk(hclk),
    .phase(phase),
    .sys_active(sys_active),
    .alarm_high(alarm_high),
    .alarm_med(alarm_med),
    .alarm_low(alarm_low),
    .recycled_agent_fraction(frac),
    .inspired_setpoint(setp)
  );

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // Steady-on bits never show low, steady-off never high, blinking shows both
  task obs(input int c);
    hi = 4'h0;
    lo = 4'h0;
    tn = 1'b0;
    repeat (c)
    begin
      @(posedge hclk);
      hi = hi | lv;
      lo = lo | ~lv;
      tn = tn | (tone_note != 2'h0);
    end
  endtask

  task ph(input aic_pkg::aic_phase_e p, input logic [7:0] fr);
    sys.mode(p, 1'b1, fr, 8'h20);
    repeat (4) @(posedge hclk);
  endtask

  task go(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l);
    sys.cond(h, m, l);
    repeat (4) @(posedge hclk);
  endtask

  task half(input int b, input int exp);
    n = 0;
    while (lv[b] !== 1'b0) @(posedge hclk);
    while (lv[b] !== 1'b1) @(posedge hclk);
    while (lv[b] === 1'b1)
    begin
      @(posedge hclk);
      n++;
    end
    chk("half period", n, exp);
  endtask

  // Starts right after a severity change, which restarts the sequence
  task notes(input int k, input logic [11:0] exp);
    logic [11:0] s;
    logic [1:0] pv;
    s = 12'h0;
    pv = 2'h0;
    while (k > 0)
    begin
      @(posedge hclk);
      if (tone_note != pv && tone_note != 2'h0)
      begin
        s = {s[9:0], tone_note};
        k--;
      end
      pv = tone_note;
    end
    chk("notes", s, exp);
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #380000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    mismatches = 0;
    checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, aic_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h2);
    bus(1'b0, aic_pkg::OFS_IRQ_MASK, 32'h0);
    chk("mask", rd, 32'h0);
    bus(1'b1, 8'h10, 32'hffffffff);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test registers done");
    rd[2:0] = lv[3:1];
    repeat (3)
    begin
      while (lv[3:1] === rd[2:0]) @(posedge hclk);
      chk("warm step", lv[3:1], {rd[1:0], rd[2]});
      rd[2:0] = lv[3:1];
    end
    go(8'h01, 8'h00, 8'h00);
    ph(aic_pkg::PH_WARM_DONE, 8'h00);
    obs(300);
    chk("warm done", {hi, lo}, 8'hf0);
    chk("warm tone", tn, 1'b0);
    chk("warm deliv", delivery_ok, 1'b0);
    go(8'h00, 8'h00, 8'h00);
    ph(aic_pkg::PH_CHECK, 8'h00);
    obs(11000);
    chk("check leds", {hi, lo}, 8'hfa);
    chk("red vs green", lv[3] ^ lv[1], 1'b1);
    ph(aic_pkg::PH_CHECK_DONE, 8'h00);
    obs(11000);
    chk("confirm wait", {hi, lo}, 8'h3e);
    $display("test phases done");
    ph(aic_pkg::PH_RUN, 8'h20);
    obs(200);
    chk("normal", {hi, lo}, 8'h3c);
    chk("normal tone", tn, 1'b0);
    chk("normal deliv", delivery_ok, 1'b1);
    chk("idle equal", delivery_idle, 1'b0);
    ph(aic_pkg::PH_RUN, 8'h21);
    chk("idle above", delivery_idle, 1'b1);
    sys.mode(aic_pkg::PH_RUN, 1'b0, 8'h21, 8'h20);
    repeat (4) @(posedge hclk);
    chk("blue off", lv[0], 1'b0);
    chk("idle inactive", delivery_idle, 1'b0);
    ph(aic_pkg::PH_RUN, 8'h00);
    go(8'h00, 8'h00, 8'h80);
    obs(200);
    chk("low", {hi, lo}, 8'h5a);
    chk("low tone", tn, 1'b0);
    bus(1'b0, aic_pkg::OFS_STATUS, 32'h0);
    chk("sev low", rd[3:0], 4'h2);
    go(8'h00, 8'h02, 8'h80);
    notes(3, 12'h01b);
    half(2, 5 * TK);
    obs(200);
    chk("medium", {hi, lo}, 8'h5e);
    chk("med deliv", delivery_ok, 1'b1);
    bus(1'b0, aic_pkg::OFS_STATUS, 32'h0);
    chk("sev med", rd[3:0], 4'h4);
    $display("test medium done");
    go(8'h00, 8'h00, 8'h80);
    go(8'h40, 8'h02, 8'h80);
    notes(5, 12'h1b6);
    half(3, 2 * TK);
    obs(200);
    chk("high", {hi, lo}, 8'h9e);
    chk("high deliv", delivery_ok, 1'b0);
    bus(1'b0, aic_pkg::OFS_STATUS, 32'h0);
    chk("sev high", rd[3:0], 4'h8);
    $display("test high done");
    bus(1'b1, aic_pkg::OFS_CTRL, 32'h3);
    // Note launched at the write edge still stands for one cycle
    repeat (2) @(posedge hclk);
    obs(150);
    chk("muted tone", tn, 1'b0);
    bus(1'b0, aic_pkg::OFS_STATUS, 32'h0);
    chk("muted flag", rd[4], 1'b1);
    n = 0;
    while (tone_note === 2'h0 && n < 12000)
    begin
      @(posedge hclk);
      n++;
    end
    chk("tone resumed", tone_note !== 2'h0, 1'b1);
    bus(1'b0, aic_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq stat", rd, 32'h7);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, aic_pkg::OFS_IRQ_MASK, 32'h7);
    repeat (3) @(posedge hclk);
    chk("irq raised", irq, 1'b1);
    bus(1'b1, aic_pkg::OFS_IRQ_STAT, 32'h7);
    repeat (3) @(posedge hclk);
    chk("irq cleared", irq, 1'b0);
    bus(1'b0, aic_pkg::OFS_IRQ_STAT, 32'h0);
    chk("stat cleared", rd, 32'h0);
    $display("test mute and interrupt done");
    stop_test();
  end
endmodule // aic_alarm_indicator_tb

/* File: verif/aic_sys_model.sv */
`timescale 1ns/100ps
module aic_sys_model (
  // Clock
  input wire logic hclk,
  // Phase and alarm conditions
  output aic_pkg::aic_phase_e phase,
  output logic sys_active,
  output logic [7:0] alarm_high,
  output logic [7:0] alarm_med,
  output logic [7:0] alarm_low,
  // Agent fractions
  output logic [7:0] recycled_agent_fraction,
  output logic [7:0] inspired_setpoint
);
  initial
  begin
    phase = aic_pkg::PH_WARM;
    sys_active = 1'b1;
    alarm_high = 8'h00;
    alarm_med = 8'h00;
    alarm_low = 8'h00;
    recycled_agent_fraction = 8'h00;
    inspired_setpoint = 8'h00;
  end

  // Levels move just after an edge, so the block never sees a half-made change
  task mode(input aic_pkg::aic_phase_e p, input logic act, input logic [7:0] fr,
    input logic [7:0] sp);
    @(posedge hclk);
    phase <= p;
    sys_active <= act;
    recycled_agent_fraction <= fr;
    inspired_setpoint <= sp;
  endtask

  task cond(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l);
    @(posedge hclk);
    alarm_high <= h;
    alarm_med <= m;
    alarm_low <= l;
  endtask
endmodule // aic_sys_model
